// ===== external_bus_unit.sv
// external bus unit: access sequencer, window decode, arbitration
`timescale 1ns/1ps
`include "ebus_params.svh"
module external_bus_unit (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    // configuration
    input  wire logic                        ext_mode,
    input  wire logic [4:0]                  addr_bits,
    input  wire logic [`EB_SEG_W-1:0]        seg_enable,
    input  wire logic                        rdy_active_high,
    input  wire logic                        arb_enable,
    input  wire logic                        arb_slave,
    input  wire logic [`EB_NWIN*`EB_TCFG_W-1:0] window_timing_config,
    input  wire logic [`EB_NWIN*`EB_FCFG_W-1:0] window_function_config,
    input  wire logic [4*`EB_ADDR_W-1:0]     window_address_select,
    input  wire logic [4*`EB_ADDR_W-1:0]     window_address_mask,
    input  wire logic [3:0]                  window_enable,
    // core and peripheral-bus request
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic                        req_periph,
    input  wire logic [`EB_ADDR_W-1:0]       req_addr,
    input  wire logic [`EB_DATA_W-1:0]       req_wdata,
    output logic                             req_ready,
    output logic                             resp_valid,
    output logic [`EB_DATA_W-1:0]            resp_rdata,
    // peripheral bus, internal copy of the external bus
    output logic                             pb_sel,
    output logic                             pb_write,
    output logic [`EB_ADDR_W-1:0]            pb_addr,
    output logic [`EB_DATA_W-1:0]            pb_wdata,
    input  wire logic [`EB_DATA_W-1:0]       pb_rdata,
    input  wire logic                        pb_ready,
    // external pins
    output logic                             bus_reference_clock_out,
    output logic [`EB_DATA_W-1:0]            ad_out,
    output logic [`EB_DATA_W-1:0]            ad_oe,
    input  wire logic [`EB_DATA_W-1:0]       ad_in,
    output logic [`EB_LOW_ADDR_W-1:0]        low_addr,
    output logic [`EB_LOW_ADDR_W-1:0]        low_addr_oe,
    output logic [`EB_SEG_W-1:0]             seg_addr,
    output logic [`EB_SEG_W-1:0]             seg_addr_oe,
    output logic                             ale,
    output logic                             rd_n,
    output logic                             wr_n,
    output logic                             strobe_oe,
    output logic [`EB_NWIN-1:0]              cs_n,
    input  wire logic                        ready_pin,
    // arbitration pins
    input  wire logic                        hold_request_n,
    output logic                             bus_request_out,
    output logic                             hold_acknowledge_out,
    output logic                             hold_acknowledge_oe,
    input  wire logic                        hold_acknowledge_in,
    // status
    output logic                             bus_held
);
    import ebus_pkg::*;

    bus_state_e            st_q;
    logic [1:0]            rdy_sync_q;
    logic [1:0]            hold_sync_q;
    logic [1:0]            hold_acknowledge_sync_q;
    logic                  rdy_s;
    logic                  hold_s;
    logic                  hold_acknowledge_s;
    logic [2:0]            win_sel;
    logic [2:0]            set_q;
    logic [`EB_TIM_W-1:0]  cnt_q;
    logic                  write_q;
    logic                  periph_q;
    logic [`EB_ADDR_W-1:0] addr_q;
    logic [`EB_DATA_W-1:0] wdata_q;
    logic [`EB_TCFG_W-1:0] tcfg;
    logic [`EB_FCFG_W-1:0] fcfg;
    logic                  mux_q;
    logic                  bus16_q;
    logic                  rdyen_q;
    logic [`EB_ADDR_W-1:0] amask;
    logic                  ref_clk_q;
    logic                  ext_go;
    logic                  rdy_ok;
    logic                  req_take;
    logic                  acc_done;
    logic                  rd_take;

    // pins from outside the domain pass two flops first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdy_sync_q  <= 2'h0;
            hold_sync_q <= 2'h3;
            hold_acknowledge_sync_q <= 2'h3;
        end else begin
            rdy_sync_q  <= {rdy_sync_q[0], ready_pin};
            hold_sync_q <= {hold_sync_q[0], hold_request_n};
            hold_acknowledge_sync_q <= {hold_acknowledge_sync_q[0], hold_acknowledge_in};
        end
    end
    assign rdy_s  = rdy_sync_q[1];
    assign hold_s = hold_sync_q[1];
    assign hold_acknowledge_s = hold_acknowledge_sync_q[1];
    assign rdy_ok = (rdy_s == rdy_active_high);

    window_select u_win (
        .addr     (req_addr),
        .win_base (window_address_select),
        .win_mask (window_address_mask),
        .win_en   (window_enable),
        .sel      (win_sel)
    );

    assign tcfg = window_timing_config[set_q*`EB_TCFG_W +: `EB_TCFG_W];
    assign fcfg = window_function_config[win_sel*`EB_FCFG_W +: `EB_FCFG_W];

    // address bits above the programmed width stay low
    always_comb begin
        for (int i = 0; i < `EB_ADDR_W; i++) begin
            amask[i] = (i < addr_bits);
        end
    end

    // in slave role an external access needs the master's grant line low
    assign ext_go = ext_mode && !(arb_enable && arb_slave && hold_acknowledge_s);
    // the core may still hold its request at the done edge; it is not taken twice
    assign req_take = req_valid && !req_ready && (req_periph || ext_go);
    assign acc_done = (st_q == ST_DATA) && (cnt_q >= tcfg[`EB_TC_HOLD +: `EB_TIM_W]);
    // pins lag the state by one cycle, so read data is taken in the first data cycle
    assign rd_take  = (st_q == ST_DATA) && (cnt_q == '0) && !write_q;

    // reference clock toggles every cycle outside idle and hold; pin changes fall on its rise or its fall
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) ref_clk_q <= 1'b0;
        else       ref_clk_q <= (st_q == ST_IDLE || st_q == ST_HOLD) ? 1'b0 : ~ref_clk_q;
    end
    assign bus_reference_clock_out = ref_clk_q;

    // access sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q     <= ST_IDLE;
            cnt_q    <= '0;
            set_q    <= 3'h0;
            write_q  <= 1'b0;
            periph_q <= 1'b0;
            addr_q   <= '0;
            wdata_q  <= '0;
            mux_q    <= 1'b0;
            bus16_q  <= 1'b0;
            rdyen_q  <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (arb_enable && !arb_slave && !hold_s) begin
                        st_q <= ST_HOLD;
                    end else if (req_take) begin
                        st_q     <= ST_ADDR;
                        set_q    <= req_periph ? 3'h0 : win_sel;
                        write_q  <= req_write;
                        periph_q <= req_periph;
                        addr_q   <= req_addr & amask;
                        wdata_q  <= req_wdata;
                        mux_q    <= fcfg[`EB_FC_MUX];
                        bus16_q  <= fcfg[`EB_FC_BUS16];
                        rdyen_q  <= fcfg[`EB_FC_RDYEN];
                        cnt_q    <= '0;
                    end
                end
                ST_ADDR: begin
                    if (cnt_q >= tcfg[`EB_TC_SETUP +: `EB_TIM_W]) begin
                        st_q  <= ST_WAIT;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_WAIT: begin
                    // waits run out first, then ready gates the end
                    if (cnt_q >= tcfg[`EB_TC_WAIT +: `EB_TIM_W]) begin
                        if (periph_q ? pb_ready : (!rdyen_q || rdy_ok)) begin
                            st_q  <= ST_DATA;
                            cnt_q <= '0;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_DATA: begin
                    if (cnt_q >= tcfg[`EB_TC_HOLD +: `EB_TIM_W]) begin
                        st_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (hold_s) st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // core handshake and read data
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req_ready  <= 1'b0;
            resp_valid <= 1'b0;
            resp_rdata <= '0;
        end else begin
            req_ready  <= acc_done;
            resp_valid <= acc_done;
            if (rd_take) begin
                if (periph_q)     resp_rdata <= pb_rdata;
                else if (bus16_q) resp_rdata <= ad_in;
                else              resp_rdata <= {8'h00, ad_in[7:0]};
            end
        end
    end

    // peripheral bus mirrors the external strobes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pb_sel   <= 1'b0;
            pb_write <= 1'b0;
            pb_addr  <= '0;
            pb_wdata <= '0;
        end else begin
            pb_sel   <= periph_q && (st_q == ST_ADDR || st_q == ST_WAIT);
            pb_write <= write_q;
            pb_addr  <= addr_q;
            pb_wdata <= wdata_q;
        end
    end

    // external pins; the bus floats while granted away
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ad_out      <= '0;
            ad_oe       <= '0;
            low_addr    <= '0;
            low_addr_oe <= '0;
            seg_addr    <= '0;
            seg_addr_oe <= '0;
            ale         <= 1'b0;
            rd_n        <= 1'b1;
            wr_n        <= 1'b1;
            strobe_oe   <= 1'b0;
            cs_n        <= '1;
        end else begin
            ale       <= 1'b0;
            rd_n      <= 1'b1;
            wr_n      <= 1'b1;
            cs_n      <= '1;
            strobe_oe <= ext_mode && (st_q != ST_HOLD);
            ad_oe     <= '0;
            seg_addr    <= addr_q[`EB_ADDR_W-1:`EB_LOW_ADDR_W];
            seg_addr_oe <= (ext_mode && st_q != ST_HOLD) ? seg_enable : '0;
            low_addr    <= addr_q[`EB_LOW_ADDR_W-1:0];
            low_addr_oe <= (ext_mode && !mux_q && st_q != ST_HOLD) ? '1 : '0;
            if (!periph_q && st_q != ST_IDLE && st_q != ST_HOLD) begin
                if (fcfg_cs(set_q)) cs_n[set_q] <= 1'b0;
                if (st_q == ST_ADDR && mux_q) begin
                    ad_out <= addr_q[`EB_DATA_W-1:0];
                    ad_oe  <= '1;
                    ale    <= 1'b1;
                end else if (st_q == ST_WAIT || st_q == ST_DATA) begin
                    rd_n <= write_q || st_q == ST_DATA;
                    wr_n <= !write_q || st_q == ST_DATA;
                    if (write_q) begin
                        ad_out <= wdata_q;
                        ad_oe  <= bus16_q ? 16'hFFFF : 16'h00FF;
                    end
                end else if (st_q == ST_ADDR) begin
                    ale <= 1'b1;
                end
            end
        end
    end

    function automatic logic fcfg_cs(input logic [2:0] idx);
        fcfg_cs = window_function_config[idx*`EB_FCFG_W + `EB_FC_CSEN];
    endfunction

    // arbitration pins stay quiet until enabled
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_request_out      <= 1'b1;
            hold_acknowledge_out <= 1'b1;
            hold_acknowledge_oe  <= 1'b0;
            bus_held             <= 1'b0;
        end else begin
            bus_held             <= (st_q == ST_HOLD);
            hold_acknowledge_oe  <= arb_enable && !arb_slave;
            hold_acknowledge_out <= !(st_q == ST_HOLD);
            // master asks for the bus back, slave asks for a grant, while the core waits
            bus_request_out <= !(arb_enable &&
                ((st_q == ST_HOLD && req_valid) || (arb_slave && hold_acknowledge_s && req_valid)));
        end
    end
endmodule

// ===== ebus_params.svh
// constants of the external bus unit
// Summary of operation
// - carry all core accesses to external memory
// - peripheral-bus accesses behave like external ones
// - single-chip mode or external bus mode
// - driven address bits programmable zero to 24
// - data path eight or sixteen bits
// - multiplexed address and data on shared lines
// - demultiplexed: low address on separate lines
// - segment lines selectable, rest freed
// - chip selects for windows plus default
// - arbitration pins only after software enable
// - master role after reset, acknowledge output
// - slave role: acknowledge pin is input
// - timing programmable per window
// - ready input with selectable active level
// - up to four address windows
// - window 4 over 3, 2 over 1
// - unmatched addresses use default set zero
// - selected window asserts its chip select
// - reference clock toggles every busy cycle; pins change on either edge
// - bus mode switches per addressed window
`ifndef EBUS_PARAMS_SVH
`define EBUS_PARAMS_SVH
`define EB_ADDR_W      24
`define EB_DATA_W      16
`define EB_NWIN        5
`define EB_LOW_ADDR_W  16
`define EB_TIM_W       4
`define EB_SEG_W       8
`define EB_TCFG_W      12
`define EB_FCFG_W      4
`define EB_TC_SETUP    0
`define EB_TC_WAIT     4
`define EB_TC_HOLD     8
`define EB_FC_MUX      0
`define EB_FC_BUS16    1
`define EB_FC_RDYEN    2
`define EB_FC_CSEN     3
`define EB_FCFG_RST    4'h8
`define EB_TCFG_RST    12'h111
`endif

// ===== ebus_pkg.sv
// types of the external bus unit
package ebus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_DATA  = 3'b011,
        ST_HOLD  = 3'b100,
        ST_GRANT = 3'b101
    } bus_state_e;
endpackage

// ===== window_select.sv
// address window decoder with fixed priority
`timescale 1ns/1ps
`include "ebus_params.svh"
module window_select (
    // access address
    input  wire logic [`EB_ADDR_W-1:0]   addr,
    // window bases and masks, index 1..4 used
    input  wire logic [4*`EB_ADDR_W-1:0] win_base,
    input  wire logic [4*`EB_ADDR_W-1:0] win_mask,
    input  wire logic [3:0]              win_en,
    // selected set index, zero is default
    output logic [2:0]                   sel
);
    logic [3:0] hit;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_hit
            assign hit[g] = win_en[g] &&
                (((addr ^ win_base[g*`EB_ADDR_W +: `EB_ADDR_W]) &
                  win_mask[g*`EB_ADDR_W +: `EB_ADDR_W]) == '0);
        end
    endgenerate
    // 4 beats 3 and 2 beats 1; the upper pair wins over the lower pair
    always_comb begin
        if (hit[3])      sel = 3'h4;
        else if (hit[2]) sel = 3'h3;
        else if (hit[1]) sel = 3'h2;
        else if (hit[0]) sel = 3'h1;
        else             sel = 3'h0;
    end
endmodule

// ===== ebus_chk.sv
// checker on the external bus unit ports
`timescale 1ns/1ps
module ebus_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // configuration
    input wire logic        ext_mode,
    input wire logic        arb_enable,
    input wire logic        arb_slave,
    input wire logic [7:0]  seg_enable,
    // bus outputs
    input wire logic [15:0] ad_oe,
    input wire logic [7:0]  seg_addr_oe,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        strobe_oe,
    input wire logic [4:0]  cs_n,
    input wire logic        bus_reference_clock_out,
    // handshake and arbitration
    input wire logic        req_ready,
    input wire logic        resp_valid,
    input wire logic        bus_held,
    input wire logic        bus_request_out,
    input wire logic        hold_acknowledge_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    a_strobe_excl: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    a_cs_onehot: assert property ($onehot0(~cs_n))
        else $error("more than one chip select low");
    a_done_pulse: assert property (req_ready |=> !req_ready)
        else $error("done pulse longer than one cycle");
    a_resp_pair: assert property (req_ready |-> resp_valid)
        else $error("done without response strobe");
    a_single_chip: assert property (!ext_mode && $past(!ext_mode) |-> &cs_n)
        else $error("chip select in single-chip mode");
    a_seg_subset: assert property ($stable(seg_enable)
        |-> (seg_addr_oe & ~seg_enable) == 8'h00) else $error("disabled segment line driven");
    a_arb_off: assert property (!arb_enable && $past(!arb_enable)
        |-> !hold_acknowledge_oe && bus_request_out) else $error("arbitration pins active");
    a_master_ack: assert property (arb_enable && !arb_slave
        && $past(arb_enable && !arb_slave) |-> hold_acknowledge_oe) else $error("ack not driven");
    a_slave_in: assert property (arb_slave && $past(arb_slave) |-> !hold_acknowledge_oe)
        else $error("ack driven in slave role");
    a_held_float: assert property (bus_held && $past(bus_held)
        |-> ad_oe == 16'h0000 && !strobe_oe && !bus_reference_clock_out)
        else $error("bus driven while held away");
    c_hold: cover property ($rose(bus_held));
    c_cs4: cover property (!cs_n[4]);
    c_done: cover property (req_ready);
endmodule
bind external_bus_unit ebus_chk chk_u (.*);

// ===== ebus_mem_model.sv
// external memory, ready source and second bus master
`timescale 1ns/1ps
module ebus_mem_model (
    // clocks
    input wire logic         sys_clk,
    input wire logic         link_clk,
    // bench controls
    input wire logic [3:0]   rdy_delay,
    input wire logic         rdy_level,
    input wire logic         hold_ask,
    input wire logic         grant,
    // bus pins
    input wire logic [15:0]  ad_out,
    input wire logic [15:0]  low_addr,
    input wire logic [15:0]  low_addr_oe,
    input wire logic         ale,
    input wire logic         rd_n,
    input wire logic         wr_n,
    output logic [15:0]      ad_in,
    output logic             ready_pin,
    output logic             hold_request_n,
    output logic             grant_n
);
    logic [15:0] mem [256];
    logic [15:0] lat_q;
    logic [15:0] junk_q = 16'hA5C3;
    logic [3:0]  cnt_q = 4'h0;
    always @(posedge sys_clk) begin
        junk_q <= ~junk_q;
        if (ale) lat_q <= (low_addr_oe != 16'h0000) ? low_addr : ad_out;
        if (!wr_n) mem[lat_q[7:0]] <= ad_out;
    end
    // released lines show a changing pattern, never the old value
    assign ad_in = !rd_n ? mem[lat_q[7:0]] : junk_q;
    always @(posedge link_clk) begin
        cnt_q <= (rd_n && wr_n) ? 4'h0 : cnt_q + 4'(cnt_q != 4'hF);
        hold_request_n <= !hold_ask;
    end
    assign ready_pin = (!(rd_n && wr_n) && cnt_q >= rdy_delay) ? rdy_level : !rdy_level;
    assign grant_n = !grant;
endmodule

// ===== external_bus_unit_tb_top.sv
// testbench of the external bus unit
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module external_bus_unit_tb_top;
    logic sys_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, ext_mode = 1'b1;
    logic rdy_active_high = 1'b1, arb_enable = 1'b0, arb_slave = 1'b0, req_valid = 1'b0;
    logic req_write = 1'b0, req_periph = 1'b0, rdy_level = 1'b1, hold_ask = 1'b0;
    logic grant = 1'b0, pb_ready = 1'b0;
    logic [4:0]  addr_bits = 5'h18;
    logic [7:0]  seg_enable = 8'hFF;
    logic [59:0] window_timing_config = {12'h141, 12'h131, 12'h121, 12'h111, 12'h101};
    logic [19:0] window_function_config = {4'hE, 4'h9, 4'hB, 4'hA, 4'hB};
    logic [95:0] window_address_select = {24'h400000, 24'h400000, 24'h100000, 24'h100000};
    logic [95:0] window_address_mask = {24'hFF0000, 24'hF00000, 24'hFF0000, 24'hF00000};
    logic [3:0]  window_enable = 4'hF, rdy_delay = 4'h0;
    logic [23:0] req_addr = 24'h0, pb_addr;
    logic [15:0] req_wdata = 16'h0, pb_rdata = 16'h0, pb_last, resp_rdata, pb_wdata;
    logic [15:0] ad_out, ad_oe, ad_in, low_addr, low_addr_oe, al_q, aoe_q;
    logic [7:0]  seg_addr, seg_addr_oe, seg_q;
    logic [4:0]  cs_n;
    logic req_ready, resp_valid, pb_sel, pb_write, bus_reference_clock_out, ale, rd_n;
    logic wr_n, strobe_oe, ready_pin, hold_request_n, bus_request_out, bus_held, grant_n;
    logic hold_acknowledge_out, hold_acknowledge_oe, hold_acknowledge_in;
    int error_cnt = 0, compares = 0, cyc = 0;
    external_bus_unit dut_u (.*);
    ebus_mem_model mem_u (.*);
    assign hold_acknowledge_in = hold_acknowledge_oe ? hold_acknowledge_out : grant_n;
    initial forever #50 sys_clk = ~sys_clk;
    initial forever #400 link_clk = ~link_clk;
    // peripheral-bus responder and run limit
    always @(posedge sys_clk) begin
        pb_ready <= pb_sel && !pb_ready;
        pb_rdata <= pb_sel ? pb_addr[15:0] ^ 16'h5A5A : ~pb_rdata;
        if (pb_sel && pb_write) pb_last <= pb_wdata;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    always @(negedge sys_clk) if (ale) begin
        al_q <= low_addr;
        aoe_q <= low_addr_oe;
        seg_q <= seg_addr;
    end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic start(input logic p, w, input logic [23:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req_periph <= p;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
    endtask
    // request is held until done is seen at a falling edge, released on the next rising edge
    task automatic fin(input int lim, output logic dn, output logic [15:0] rd,
                       output logic [4:0] cs, output int n);
        cs = 5'h1F;
        n = 0;
        do begin
            @(negedge sys_clk);
            cs &= cs_n;
            n++;
        end while (req_ready !== 1'b1 && n < lim);
        dn = req_ready;
        rd = resp_rdata;
        if (dn) @(posedge sys_clk) req_valid <= 1'b0;
    endtask
    task automatic xfer(input logic p, w, input logic [23:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic [4:0] cs, output int n);
        logic dn;
        start(p, w, a, d);
        fin(400, dn, rd, cs, n);
        `CHK(dn, 1'b1)
    endtask
    task automatic t_reset();
        `CHK({cs_n, rd_n, wr_n, strobe_oe, bus_reference_clock_out}, 9'h1FC)
        `CHK({hold_acknowledge_oe, hold_acknowledge_out, bus_request_out}, 3'b011)
        $display("test reset done");
    endtask
    task automatic t_single();
        logic [15:0] rd;
        logic [4:0] cs;
        logic dn;
        int n;
        @(posedge sys_clk) ext_mode <= 1'b0;
        xfer(1'b1, 1'b0, 24'h201234, 16'h0, rd, cs, n);
        `CHK(rd, 16'h1234 ^ 16'h5A5A)
        xfer(1'b1, 1'b1, 24'h204000, 16'h3C3C, rd, cs, n);
        `CHK(pb_last, 16'h3C3C)
        start(1'b0, 1'b0, 24'h800A10, 16'h0);
        fin(40, dn, rd, cs, n);
        `CHK({dn, cs}, 6'h1F)
        @(posedge sys_clk) ext_mode <= 1'b1;
        fin(400, dn, rd, cs, n);
        `CHK(dn, 1'b1)
        $display("test single-chip done");
    endtask
    task automatic t_windows();
        logic [23:0] at [5] = '{24'h800A10, 24'h120B21, 24'h100C32, 24'h450D43, 24'h400E54};
        logic [15:0] rd, d;
        logic [4:0] cs;
        int n;
        for (int s = 0; s < 5; s++) begin
            d = 16'hA5F0 + 16'(s);
            xfer(1'b0, 1'b1, at[s], d, rd, cs, n);
            xfer(1'b0, 1'b0, at[s], 16'h0, rd, cs, n);
            `CHK(cs, ~(5'h01 << s))
            `CHK(rd, (s == 3) ? {8'h00, d[7:0]} : d)
            `CHK(n >= 6 + s, 1'b1)
            `CHK(aoe_q != 16'h0, s == 1 || s == 4)
            if (s == 1 || s == 4) `CHK(al_q, at[s][15:0])
        end
        @(posedge sys_clk) window_enable <= 4'hD;
        xfer(1'b0, 1'b0, 24'h100C32, 16'h0, rd, cs, n);
        `CHK({cs, rd}, {5'h1D, 16'hA5F2})
        @(posedge sys_clk) window_enable <= 4'hF;
        $display("test windows done");
    endtask
    task automatic t_ready();
        logic [15:0] rd;
        logic [4:0] cs;
        int n;
        for (int l = 0; l < 2; l++) begin
            @(posedge sys_clk);
            rdy_active_high <= l[0];
            rdy_level <= l[0];
            rdy_delay <= 4'h6;
            xfer(1'b0, 1'b0, 24'h400E54, 16'h0, rd, cs, n);
            `CHK({n >= 40, rd}, {1'b1, 16'hA5F4})
        end
        @(posedge sys_clk) rdy_delay <= 4'h0;
        $display("test ready done");
    endtask
    task automatic t_width();
        logic [15:0] rd;
        logic [4:0] cs;
        int n;
        @(posedge sys_clk) addr_bits <= 5'h0C;
        xfer(1'b0, 1'b0, 24'h12F6B1, 16'h0, rd, cs, n);
        `CHK({seg_q, al_q}, 24'h0006B1)
        @(posedge sys_clk);
        addr_bits <= 5'h14;
        seg_enable <= 8'h0F;
        xfer(1'b0, 1'b0, 24'h12F6B1, 16'h0, rd, cs, n);
        `CHK({seg_q, al_q}, 24'h02F6B1)
        `CHK(seg_addr_oe, 8'h0F)
        @(posedge sys_clk);
        addr_bits <= 5'h18;
        seg_enable <= 8'hFF;
        $display("test width done");
    endtask
    task automatic t_arb();
        logic [15:0] rd;
        logic [4:0] cs;
        logic dn;
        int n;
        @(posedge sys_clk);
        arb_enable <= 1'b1;
        hold_ask <= 1'b1;
        for (int i = 0; i < 40 && bus_held !== 1'b1; i++) @(negedge sys_clk);
        `CHK({bus_held, hold_acknowledge_oe, hold_acknowledge_out}, 3'b110)
        `CHK({ad_oe, strobe_oe}, 17'h0)
        start(1'b0, 1'b0, 24'h800A10, 16'h0);
        fin(30, dn, rd, cs, n);
        `CHK(dn, 1'b0)
        @(posedge sys_clk) hold_ask <= 1'b0;
        fin(400, dn, rd, cs, n);
        `CHK({dn, rd}, {1'b1, 16'hA5F0})
        @(posedge sys_clk) arb_slave <= 1'b1;
        start(1'b0, 1'b0, 24'h100C32, 16'h0);
        fin(30, dn, rd, cs, n);
        `CHK({dn, hold_acknowledge_oe}, 2'b00)
        @(posedge sys_clk) grant <= 1'b1;
        fin(400, dn, rd, cs, n);
        `CHK({dn, rd}, {1'b1, 16'hA5F2})
        @(posedge sys_clk);
        arb_slave <= 1'b0;
        arb_enable <= 1'b0;
        grant <= 1'b0;
        hold_ask <= 1'b1;
        xfer(1'b0, 1'b0, 24'h800A10, 16'h0, rd, cs, n);
        `CHK({bus_held, rd}, {1'b0, 16'hA5F0})
        @(posedge sys_clk) hold_ask <= 1'b0;
        $display("test arbitration done");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_single();
        t_windows();
        t_ready();
        t_width();
        t_arb();
        results();
    end
endmodule
